// ---- inc/flash_regs_pkg.sv ----
// Constants, types and field layout of the protocol and status register bank
package flash_regs_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int STATUS_WRITE_NS = 1000;
  localparam int NV_WRITE_NS     = 1500;
  localparam int ARRAY_OP_NS     = 2000;
  // Least times, rounded up to whole cycles
  localparam int STATUS_WRITE_CYC = (STATUS_WRITE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int NV_WRITE_CYC     = (NV_WRITE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ARRAY_OP_CYC     = (ARRAY_OP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W            = 16;

  // ==========================================================
  // Status register fields
  localparam int ST_W          = 8;
  localparam int ST_SRWD_BIT   = 7;
  localparam int ST_PROTECT_SIZE_MSB_BIT = 6;
  localparam int ST_TB_BIT     = 5;
  localparam int ST_BP_LO_BIT  = 2;
  localparam int ST_WEL_BIT    = 1;
  localparam int ST_WIP_BIT    = 0;
  localparam logic [7:0] ST_NV_MASK = 8'hfc;

  // ==========================================================
  // Configuration register fields
  localparam int NVCR_W          = 16;
  localparam int NVCR_QUAD_BIT   = 3;
  localparam int NVCR_DUAL_BIT   = 2;
  localparam int NVCR_DUMMY_LO   = 12;
  localparam int VCR_DUMMY_LO    = 4;
  localparam int EVCR_QUAD_BIT   = 7;
  localparam int EVCR_DUAL_BIT   = 6;
  localparam logic [15:0] NVCR_FACTORY = 16'hffff;
  localparam logic [7:0]  VCR_RESET    = 8'hfb;
  localparam logic [7:0]  EVCR_RESET   = 8'hdf;
  localparam logic [7:0]  EVCR_EXT     = 8'hc0;

  // ==========================================================
  // Array geometry and protection
  localparam int SECTOR_W     = 10;
  localparam int SECTORS      = 1024;
  localparam int BP_ALL_LEVEL = 11;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} proto_t;

  typedef enum logic [3:0] {
    OP_NONE, OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_WRITE_STATUS,
    OP_WRITE_VCR, OP_WRITE_EVCR, OP_WRITE_NVCR, OP_PROGRAM,
    OP_ERASE, OP_DIE_ERASE, OP_CLEAR_FLAGS, OP_RESCUE
  } op_t;

  typedef struct packed {
    logic                valid;
    op_t                 op;
    logic [15:0]         data;
    logic [SECTOR_W-1:0] sector;
  } cmd_req_t;

  typedef struct packed {
    proto_t     proto;
    logic [2:0] cmd_lanes;
    logic [3:0] dummy_cycles;
  } link_cfg_t;

endpackage

// ---- verilog/flash_protocol_status.sv ----
// Protocol selection, working configuration and status/protection register bank
//
// Notes on behaviour
// - Extended protocol sends command on one line
// - EVCR bit6=0, bit7=1 gives dual at once
// - EVCR bit7=0 gives quad at once
// - Volatile protocol reverts on reset, rescue, EVCR
// - NVCR bit2=0, bit3=1 boots into dual protocol
// - NVCR bit3=0 boots into quad protocol
// - Quad busy with high voltage accepts extended
// - Boot loads working config from NVCR
// - VCR and EVCR writes update working config
// - SRWD with write protect low blocks status
// - Top/bottom bit anchors protected range
// - WEL clear at power-up, needed for status, NVCR, program and erase
// - WIP high while write/program/erase busy
// - Volatile status bits cleared by reset
// - Die erase only with all BP zero
// - Protection error keeps WEL until clear-flags
// - Controller ready flag is inverse of WIP
// - Serial sampling edges and modes 0/3 (not handled here; left to the serial front end)
// - Both NV protocol bits zero means quad
`timescale 1ns/100ps

module flash_protocol_status #(
  parameter int STATUS_WRITE_CYC = flash_regs_pkg::STATUS_WRITE_CYC,
  parameter int NV_WRITE_CYC     = flash_regs_pkg::NV_WRITE_CYC,
  parameter int ARRAY_OP_CYC     = flash_regs_pkg::ARRAY_OP_CYC
) (
  // Clock and power-on/software reset
  input  wire logic                        i_clk,
  input  wire logic                        i_reset,
  // Factory state of nonvolatile cells, sampled during reset
  input  wire logic                        i_nv_factory_init,
  // Decoded command from the serial front end
  input  wire flash_regs_pkg::cmd_req_t    i_cmd,
  output logic                             o_cmd_ready,
  // Pins
  input  wire logic                        i_write_protect_n,
  input  wire logic                        i_highvolt_assist_input,
  // Register read back
  output logic [flash_regs_pkg::ST_W-1:0]   o_device_status_protection,
  output logic [flash_regs_pkg::NVCR_W-1:0] o_nvcr,
  output logic [7:0]                       o_vcr,
  output logic [7:0]                       o_evcr,
  // Flag status bits
  output logic                             o_pe_ctrl_ready,
  output logic                             o_protection_error,
  // Link configuration for the serial front end
  output flash_regs_pkg::link_cfg_t         o_link_cfg,
  // Array engine strobe
  output logic                             o_array_start,
  output flash_regs_pkg::op_t               o_array_op,
  output logic [flash_regs_pkg::SECTOR_W-1:0] o_array_sector
);

  // ==========================================================
  // Types and state
  typedef enum logic {ST_IDLE, ST_BUSY} fsm_t;

  typedef struct packed {
    fsm_t                                   fsm;
    logic [flash_regs_pkg::ST_W-1:0]        status;
    logic [flash_regs_pkg::NVCR_W-1:0]      nvcr;
    logic [7:0]                             vcr;
    logic [7:0]                             evcr;
    flash_regs_pkg::proto_t                 proto;
    logic [3:0]                             dummy;
    logic                                   prot_err;
    flash_regs_pkg::op_t                    op;
    logic [15:0]                            pend;
    logic [flash_regs_pkg::SECTOR_W-1:0]    sector;
    logic [flash_regs_pkg::CNT_W-1:0]       cnt;
    logic                                   start;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ==========================================================
  // Helpers
  function automatic flash_regs_pkg::proto_t proto_from_bits(input logic quad_n,
                                                             input logic dual_n);
    if (!quad_n) begin
      return flash_regs_pkg::PROTO_QUAD;
    end else if (!dual_n) begin
      return flash_regs_pkg::PROTO_DUAL;
    end
    return flash_regs_pkg::PROTO_EXT;
  endfunction

  // Protected span: none, 2^(n-1) sectors, or the whole array
  function automatic logic sector_protected(input logic [flash_regs_pkg::SECTOR_W-1:0] sec,
                                            input logic [3:0] bp,
                                            input logic tb);
    logic [flash_regs_pkg::SECTOR_W:0] size;
    logic [flash_regs_pkg::SECTOR_W:0] sec_w;
    size  = '0;
    sec_w = {1'b0, sec};
    if (bp == 4'h0) begin
      return 1'b0;
    end
    if (32'(bp) >= flash_regs_pkg::BP_ALL_LEVEL) begin
      return 1'b1;
    end
    size = (flash_regs_pkg::SECTOR_W+1)'(1) << (bp - 4'h1);
    if (tb) begin
      return sec_w < size;
    end
    return sec_w >= ((flash_regs_pkg::SECTOR_W+1)'(flash_regs_pkg::SECTORS) - size);
  endfunction

  function automatic logic [3:0] bp_of(input logic [7:0] st);
    return {st[flash_regs_pkg::ST_PROTECT_SIZE_MSB_BIT], st[flash_regs_pkg::ST_BP_LO_BIT+2 -: 3]};
  endfunction

  // ==========================================================
  // Next state
  logic                             wel;
  logic                             status_locked;
  logic [3:0]                       bp;
  logic                             tb;

  always_comb begin
    s_d       = s_q;
    s_d.start = 1'b0;
    wel       = s_q.status[flash_regs_pkg::ST_WEL_BIT];
    bp        = bp_of(s_q.status);
    tb        = s_q.status[flash_regs_pkg::ST_TB_BIT];
    // Hardware protection of the status register
    status_locked = s_q.status[flash_regs_pkg::ST_SRWD_BIT] && !i_write_protect_n;

    case (s_q.fsm)
      ST_IDLE: begin
        if (i_cmd.valid) begin
          case (i_cmd.op)
            flash_regs_pkg::OP_WRITE_ENABLE: begin
              s_d.status[flash_regs_pkg::ST_WEL_BIT] = 1'b1;
            end
            flash_regs_pkg::OP_WRITE_DISABLE: begin
              // Latch stays set after a protection error
              if (!s_q.prot_err) begin
                s_d.status[flash_regs_pkg::ST_WEL_BIT] = 1'b0;
              end
            end
            flash_regs_pkg::OP_CLEAR_FLAGS: begin
              s_d.prot_err = 1'b0;
              if (s_q.prot_err) begin
                s_d.status[flash_regs_pkg::ST_WEL_BIT] = 1'b0;
              end
            end
            flash_regs_pkg::OP_WRITE_STATUS: begin
              if (wel && !status_locked) begin
                s_d.fsm  = ST_BUSY;
                s_d.op   = i_cmd.op;
                s_d.pend = i_cmd.data;
                s_d.cnt  = flash_regs_pkg::CNT_W'(STATUS_WRITE_CYC - 1);
                s_d.status[flash_regs_pkg::ST_WIP_BIT] = 1'b1;
              end
            end
            flash_regs_pkg::OP_WRITE_NVCR: begin
              if (wel) begin
                s_d.fsm  = ST_BUSY;
                s_d.op   = i_cmd.op;
                s_d.pend = i_cmd.data;
                s_d.cnt  = flash_regs_pkg::CNT_W'(NV_WRITE_CYC - 1);
                s_d.status[flash_regs_pkg::ST_WIP_BIT] = 1'b1;
              end
            end
            flash_regs_pkg::OP_WRITE_VCR: begin
              s_d.vcr   = i_cmd.data[7:0];
              s_d.dummy = i_cmd.data[flash_regs_pkg::VCR_DUMMY_LO +: 4];
            end
            flash_regs_pkg::OP_WRITE_EVCR: begin
              // Each fresh write reselects protocol, so 11 returns to extended
              s_d.evcr  = i_cmd.data[7:0];
              s_d.proto = proto_from_bits(i_cmd.data[flash_regs_pkg::EVCR_QUAD_BIT],
                                          i_cmd.data[flash_regs_pkg::EVCR_DUAL_BIT]);
            end
            flash_regs_pkg::OP_RESCUE: begin
              s_d.evcr  = s_q.evcr | flash_regs_pkg::EVCR_EXT;
              s_d.proto = flash_regs_pkg::PROTO_EXT;
            end
            flash_regs_pkg::OP_PROGRAM,
            flash_regs_pkg::OP_ERASE,
            flash_regs_pkg::OP_DIE_ERASE: begin
              if (wel) begin
                if ((i_cmd.op == flash_regs_pkg::OP_DIE_ERASE) ? (bp != 4'h0)
                    : sector_protected(i_cmd.sector, bp, tb)) begin
                  // Refused: flag error and hold the latch
                  s_d.prot_err = 1'b1;
                end else begin
                  s_d.fsm    = ST_BUSY;
                  s_d.op     = i_cmd.op;
                  s_d.sector = i_cmd.sector;
                  s_d.start  = 1'b1;
                  s_d.cnt    = flash_regs_pkg::CNT_W'(ARRAY_OP_CYC - 1);
                  s_d.status[flash_regs_pkg::ST_WIP_BIT] = 1'b1;
                end
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_BUSY: begin
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - flash_regs_pkg::CNT_W'(1);
        end else begin
          s_d.fsm = ST_IDLE;
          s_d.status[flash_regs_pkg::ST_WIP_BIT] = 1'b0;
          s_d.status[flash_regs_pkg::ST_WEL_BIT] = 1'b0;
          if (s_q.op == flash_regs_pkg::OP_WRITE_STATUS) begin
            // Only nonvolatile bits take the written value
            s_d.status = (s_q.pend[7:0] & flash_regs_pkg::ST_NV_MASK);
          end
          if (s_q.op == flash_regs_pkg::OP_WRITE_NVCR) begin
            // Takes effect at next boot only
            s_d.nvcr = s_q.pend;
          end
        end
      end
      default: begin
        s_d.fsm = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  // Decoded commands are sampled on the rising edge only
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      // Nonvolatile cells keep their contents across reset unless i_nv_factory_init loads the factory state
      s_q.status <= s_q.status & flash_regs_pkg::ST_NV_MASK;
      s_q.nvcr   <= s_q.nvcr;
      if (i_nv_factory_init) begin
        s_q.status <= '0;
        s_q.nvcr   <= flash_regs_pkg::NVCR_FACTORY;
      end
      s_q.fsm      <= ST_IDLE;
      s_q.vcr      <= flash_regs_pkg::VCR_RESET;
      s_q.evcr     <= flash_regs_pkg::EVCR_RESET;
      s_q.prot_err <= 1'b0;
      s_q.op       <= flash_regs_pkg::OP_NONE;
      s_q.pend     <= '0;
      s_q.sector   <= '0;
      s_q.cnt      <= '0;
      s_q.start    <= 1'b0;
      // Working configuration loaded from the nonvolatile image
      s_q.dummy    <= i_nv_factory_init ? flash_regs_pkg::NVCR_FACTORY[flash_regs_pkg::NVCR_DUMMY_LO +: 4]
                                        : s_q.nvcr[flash_regs_pkg::NVCR_DUMMY_LO +: 4];
      s_q.proto    <= i_nv_factory_init ? flash_regs_pkg::PROTO_EXT
                                        : proto_from_bits(s_q.nvcr[flash_regs_pkg::NVCR_QUAD_BIT],
                                                          s_q.nvcr[flash_regs_pkg::NVCR_DUAL_BIT]);
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  flash_regs_pkg::proto_t live_proto;

  always_comb begin
    live_proto = s_q.proto;
    // Extended framing lets the host poll or suspend during a high-voltage cycle
    if (s_q.proto == flash_regs_pkg::PROTO_QUAD && s_q.fsm == ST_BUSY && i_highvolt_assist_input) begin
      live_proto = flash_regs_pkg::PROTO_EXT;
    end
  end

  always_comb begin
    o_link_cfg.proto        = live_proto;
    o_link_cfg.dummy_cycles = s_q.dummy;
    // Sampling edges and idle clock level are handled by the serial front end
    case (live_proto)
      flash_regs_pkg::PROTO_DUAL: o_link_cfg.cmd_lanes = 3'h2;
      flash_regs_pkg::PROTO_QUAD: o_link_cfg.cmd_lanes = 3'h4;
      default:                    o_link_cfg.cmd_lanes = 3'h1;
    endcase
  end

  assign o_cmd_ready                = (s_q.fsm == ST_IDLE);
  assign o_device_status_protection = s_q.status;
  assign o_nvcr                     = s_q.nvcr;
  assign o_vcr                      = s_q.vcr;
  assign o_evcr                     = s_q.evcr;
  assign o_pe_ctrl_ready            = ~s_q.status[flash_regs_pkg::ST_WIP_BIT];
  assign o_protection_error         = s_q.prot_err;
  assign o_array_start              = s_q.start;
  assign o_array_op                 = s_q.op;
  assign o_array_sector             = s_q.sector;

endmodule // flash_protocol_status

// ---- testbench/flash_protocol_status_checker.sv ----
// Concurrent checks on the ports of the protocol and status register bank
`timescale 1ns/100ps
module flash_protocol_status_checker #(
  parameter int STATUS_WRITE_CYC = flash_regs_pkg::STATUS_WRITE_CYC,
  parameter int NV_WRITE_CYC     = flash_regs_pkg::NV_WRITE_CYC,
  parameter int ARRAY_OP_CYC     = flash_regs_pkg::ARRAY_OP_CYC
) (
  // Clock, reset and command side
  input wire logic                      i_clk,
  input wire logic                      i_reset,
  input wire flash_regs_pkg::cmd_req_t  i_cmd,
  input wire logic                      o_cmd_ready,
  input wire logic                      i_write_protect_n,
  // Observed register and link outputs
  input wire logic [7:0]                o_device_status_protection,
  input wire logic [15:0]               o_nvcr,
  input wire logic                      o_pe_ctrl_ready,
  input wire logic                      o_protection_error,
  input wire flash_regs_pkg::link_cfg_t o_link_cfg,
  input wire logic                      o_array_start
);
  // ==========================================================
  // Helpers
  localparam int SW_HI = STATUS_WRITE_CYC - 1;
  wire logic [7:0] st = o_device_status_protection;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence took(flash_regs_pkg::op_t k);
    i_cmd.valid && o_cmd_ready && i_cmd.op == k;
  endsequence
  sequence locked_sw;
    took(flash_regs_pkg::OP_WRITE_STATUS) ##0 (st[7] && !i_write_protect_n);
  endsequence
  // ==========================================================
  // Assertions
  ready_inverse_a: assert property (o_pe_ctrl_ready == !st[0])
    else $error("controller ready flag is not the inverse of busy");
  reset_clear_a: assert property ($fell(i_reset) |-> st[1:0] == 2'h0 && !o_protection_error)
    else $error("volatile status bits not cleared by reset");
  boot_proto_a: assert property ($fell(i_reset) |-> o_link_cfg.proto == (!o_nvcr[3] ? flash_regs_pkg::PROTO_QUAD :
    !o_nvcr[2] ? flash_regs_pkg::PROTO_DUAL : flash_regs_pkg::PROTO_EXT)) else $error("boot protocol mismatch");
  sw_busy_a: assert property (took(flash_regs_pkg::OP_WRITE_STATUS) ##0 (st[1] && !(st[7] && !i_write_protect_n))
    |-> ##1 st[0] ##SW_HI st[0] ##1 !st[0]) else $error("status write busy time wrong");
  sw_locked_a: assert property (locked_sw |=> st == $past(st))
    else $error("locked status register changed");
  wel_needed_a: assert property (took(flash_regs_pkg::OP_PROGRAM) ##0 !st[1] |=> !o_array_start && !st[0])
    else $error("program ran without write enable");
  evcr_quad_a: assert property (took(flash_regs_pkg::OP_WRITE_EVCR) ##0 !i_cmd.data[7]
    |=> o_link_cfg.proto == flash_regs_pkg::PROTO_QUAD && o_link_cfg.cmd_lanes == 3'h4) else $error("no quad");
  evcr_dual_a: assert property (took(flash_regs_pkg::OP_WRITE_EVCR) ##0 i_cmd.data[7:6] == 2'h2
    |=> o_link_cfg.proto == flash_regs_pkg::PROTO_DUAL && o_link_cfg.cmd_lanes == 3'h2) else $error("no dual");
  evcr_ext_a: assert property (took(flash_regs_pkg::OP_WRITE_EVCR) ##0 i_cmd.data[7:6] == 2'h3
    |=> o_link_cfg.proto == flash_regs_pkg::PROTO_EXT && o_link_cfg.cmd_lanes == 3'h1) else $error("no extended");
  die_refuse_a: assert property (took(flash_regs_pkg::OP_DIE_ERASE) ##0 (st[1] && (st[6] || st[4:2] != 3'h0))
    |=> !o_array_start && o_protection_error && st[1]) else $error("die erase ran with protection set");
endmodule // flash_protocol_status_checker

bind flash_protocol_status flash_protocol_status_checker #(.STATUS_WRITE_CYC(STATUS_WRITE_CYC),
  .NV_WRITE_CYC(NV_WRITE_CYC), .ARRAY_OP_CYC(ARRAY_OP_CYC)) i_chk (.i_clk, .i_reset, .i_cmd, .o_cmd_ready,
  .i_write_protect_n, .o_device_status_protection, .o_nvcr, .o_pe_ctrl_ready, .o_protection_error, .o_link_cfg,
  .o_array_start);

// ---- testbench/spi_host_model.sv ----
// Host model that issues decoded commands to the register bank
`timescale 1ns/100ps
module spi_host_model (
  // Clock and handshake
  input  wire logic                i_clk,
  input  wire logic                i_ready,
  // Command to the device
  output flash_regs_pkg::cmd_req_t o_cmd
);
  initial o_cmd = '0;
  // Called at a falling edge; fields scrambled once released so stale data never looks valid
  task automatic send(input flash_regs_pkg::op_t op, input logic [15:0] d, input logic [9:0] s, output bit ok);
    int n;
    n = 0;
    // Idle edge first, so valid never gets two drives in one time step
    @(negedge i_clk);
    while (i_ready !== 1'b1 && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    ok = (i_ready === 1'b1);
    o_cmd <= '{1'b1, op, d, s};
    @(negedge i_clk);
    o_cmd <= '{1'b0, flash_regs_pkg::OP_NONE, ~d, ~s};
  endtask
endmodule // spi_host_model

// ---- testbench/flash_protocol_status_tb.sv ----
// Self-checking bench for the protocol and status register bank
`timescale 1ns/100ps
module flash_protocol_status_tb;
  localparam int SW = 3;
  localparam int NV = 4;
  localparam int AR = 5;
  logic i_clk = 1'b0, i_reset = 1'b1, i_nv_factory_init = 1'b1, i_write_protect_n = 1'b1, i_highvolt_assist_input = 1'b0;
  logic o_cmd_ready, o_pe_ctrl_ready, o_protection_error, o_array_start;
  logic [7:0] st, o_vcr, o_evcr;
  logic [15:0] o_nvcr;
  logic [9:0] o_array_sector;
  flash_regs_pkg::cmd_req_t  i_cmd;
  flash_regs_pkg::link_cfg_t lc;
  flash_regs_pkg::op_t       o_array_op;
  int num_errors = 0, total_checks = 0;
  always #2.5 i_clk = ~i_clk;
  flash_protocol_status #(.STATUS_WRITE_CYC(SW), .NV_WRITE_CYC(NV), .ARRAY_OP_CYC(AR)) i_dut (.i_clk, .i_reset,
    .i_nv_factory_init, .i_cmd, .o_cmd_ready, .i_write_protect_n, .i_highvolt_assist_input,
    .o_device_status_protection(st), .o_nvcr, .o_vcr, .o_evcr, .o_pe_ctrl_ready, .o_protection_error,
    .o_link_cfg(lc), .o_array_start, .o_array_op, .o_array_sector);
  spi_host_model i_host (.i_clk, .i_ready(o_cmd_ready), .o_cmd(i_cmd));
  // ==========================================================
  // Shared tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cmd(input flash_regs_pkg::op_t op, input logic [15:0] d = 16'h0, input logic [9:0] s = 10'h0);
    bit ok;
    i_host.send(op, d, s, ok);
    if (!ok) begin
      num_errors++;
      $display("ERROR %0t device never ready", $time);
      tally_and_finish();
    end
  endtask
  // Counts cycles with busy still set, starting in the cycle after the take
  task automatic busy_for(input int n);
    int c;
    c = 0;
    while (st[0] === 1'b1 && c < 2000) begin
      @(negedge i_clk);
      c++;
    end
    check(16'(c), 16'(n), "busy length");
  endtask
  task automatic do_reset(input logic factory);
    i_nv_factory_init = factory;
    i_reset = 1'b1;
    repeat (16) @(negedge i_clk);
    i_reset = 1'b0;
    @(negedge i_clk);
  endtask
  task automatic set_status(input logic [7:0] v);
    cmd(flash_regs_pkg::OP_WRITE_ENABLE);
    cmd(flash_regs_pkg::OP_WRITE_STATUS, {8'h0, v});
    busy_for(SW);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    cmd(flash_regs_pkg::OP_WRITE_ENABLE);
    do_reset(1'b1);
    check(16'(st), 16'h0000, "status after reset");
    check(o_nvcr, 16'hffff, "nvcr factory");
    check({o_vcr, o_evcr}, 16'hfbdf, "volatile config reset");
    check(16'(lc.proto), 16'(flash_regs_pkg::PROTO_EXT), "default protocol");
    check(16'(lc.cmd_lanes), 16'h0001, "command on one line");
    $display("reset test done");
  endtask
  task automatic t_protocols();
    logic [7:0] ev [5] = '{8'h7f, 8'hbf, 8'hff, 8'h3f, 8'hdf};
    logic [2:0] ln [5] = '{3'h4, 3'h2, 3'h1, 3'h4, 3'h1};
    for (int i = 0; i < 5; i++) begin
      cmd(flash_regs_pkg::OP_WRITE_EVCR, {8'h0, ev[i]});
      check(16'(lc.cmd_lanes), 16'(ln[i]), "lanes after evcr write");
    end
    cmd(flash_regs_pkg::OP_RESCUE);
    check(16'(lc.proto), 16'(flash_regs_pkg::PROTO_EXT), "rescue");
    cmd(flash_regs_pkg::OP_WRITE_VCR, 16'h005b);
    check(16'(lc.dummy_cycles), 16'h0005, "vcr dummy cycles live");
    $display("protocol test done");
  endtask
  task automatic t_status();
    cmd(flash_regs_pkg::OP_WRITE_STATUS, 16'h009c);
    check(16'(st), 16'h0000, "write without latch");
    set_status(8'h9c);
    check(16'(st), 16'h009c, "status written");
    cmd(flash_regs_pkg::OP_WRITE_ENABLE);
    i_write_protect_n = 1'b0;
    cmd(flash_regs_pkg::OP_WRITE_STATUS, 16'h0000);
    check(16'(st), 16'h009e, "locked status");
    i_write_protect_n = 1'b1;
    cmd(flash_regs_pkg::OP_WRITE_STATUS, 16'h0024);
    check(16'(o_pe_ctrl_ready), 16'h0000, "controller busy");
    check(16'(o_cmd_ready), 16'h0000, "busy refuses commands");
    busy_for(SW);
    check(16'(st), 16'h0024, "unlocked status");
    $display("status test done");
  endtask
  task automatic t_protect();
    cmd(flash_regs_pkg::OP_PROGRAM, 16'h0, 10'h3ff);
    check({15'h0, o_array_start}, 16'h0000, "program without latch");
    cmd(flash_regs_pkg::OP_WRITE_ENABLE);
    cmd(flash_regs_pkg::OP_PROGRAM, 16'h0, 10'h000);
    check({15'h0, o_array_start}, 16'h0000, "bottom sector refused");
    cmd(flash_regs_pkg::OP_WRITE_DISABLE);
    check({14'h0, o_protection_error, st[1]}, 16'h0003, "error keeps latch");
    cmd(flash_regs_pkg::OP_CLEAR_FLAGS);
    check({14'h0, o_protection_error, st[1]}, 16'h0000, "flags cleared");
    cmd(flash_regs_pkg::OP_WRITE_ENABLE);
    cmd(flash_regs_pkg::OP_PROGRAM, 16'h0, 10'h3ff);
    check({5'h0, o_array_start, o_array_sector}, 16'h07ff, "top sector runs");
    busy_for(AR);
    set_status(8'h04);
    cmd(flash_regs_pkg::OP_WRITE_ENABLE);
    cmd(flash_regs_pkg::OP_ERASE, 16'h0, 10'h3ff);
    check({15'h0, o_protection_error}, 16'h0001, "top anchored");
    cmd(flash_regs_pkg::OP_DIE_ERASE);
    check({15'h0, o_array_start}, 16'h0000, "die erase refused");
    cmd(flash_regs_pkg::OP_CLEAR_FLAGS);
    set_status(8'h00);
    cmd(flash_regs_pkg::OP_WRITE_ENABLE);
    cmd(flash_regs_pkg::OP_DIE_ERASE);
    check({11'h0, o_array_start, o_array_op}, 16'h0019, "die erase runs");
    busy_for(AR);
    $display("protection test done");
  endtask
  task automatic t_highvolt();
    cmd(flash_regs_pkg::OP_WRITE_EVCR, 16'h007f);
    cmd(flash_regs_pkg::OP_WRITE_ENABLE);
    i_highvolt_assist_input = 1'b1;
    cmd(flash_regs_pkg::OP_PROGRAM, 16'h0, 10'h100);
    check(16'(lc.proto), 16'(flash_regs_pkg::PROTO_EXT), "extended while assisted");
    i_highvolt_assist_input = 1'b0;
    #1;
    check(16'(lc.proto), 16'(flash_regs_pkg::PROTO_QUAD), "quad restored");
    @(negedge i_clk);
    busy_for(AR - 1);
    $display("high voltage test done");
  endtask
  task automatic t_boot();
    logic [15:0] nv [3] = '{16'hfff3, 16'hfffb, 16'hffff};
    logic [2:0]  ln [3] = '{3'h4, 3'h2, 3'h1};
    for (int i = 0; i < 3; i++) begin
      cmd(flash_regs_pkg::OP_WRITE_ENABLE);
      cmd(flash_regs_pkg::OP_WRITE_NVCR, nv[i]);
      busy_for(NV);
      cmd(flash_regs_pkg::OP_WRITE_EVCR, 16'h00bf);
      do_reset(1'b0);
      check(16'(lc.cmd_lanes), 16'(ln[i]), "boot protocol");
      check(16'(o_evcr), 16'h00df, "volatile choice dropped");
    end
    $display("boot test done");
  endtask
  initial begin
    do_reset(1'b1);
    t_reset();
    t_protocols();
    t_status();
    t_protect();
    t_highvolt();
    t_boot();
    tally_and_finish();
  end
endmodule // flash_protocol_status_tb
